//--- hw/dcg_axis_time.sv
/*
  one axis: deceleration check time in clock cycles and
  in-position flag. purely combinational.
  assumes configuration words held stable by the top.
*/
`include "dcg_consts.svh"
module dcg_axis_time
    import dcg_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `DCG_CYC_PER_MS
)
(
    input  wire dcg_acc_cfg_t        i_rapid_cfg,
    input  wire dcg_acc_cfg_t        i_cut_cfg,
    input  wire logic                i_use_cut,
    input  wire logic [3:0]          i_margin_ms,
    input  wire logic [`DCG_ERRW-1:0] i_servo_width,
    input  wire logic [`DCG_ERRW-1:0] i_rapid_width,
    input  wire logic [`DCG_ERRW-1:0] i_cut_width,
    input  wire logic [`DCG_ERRW-1:0] i_pos_err,
    output logic [31:0]              o_td_cyc,
    output logic                     o_in_pos
);

    dcg_acc_cfg_t         cfg;
    logic [13:0]          td_ms;
    logic [`DCG_ERRW-1:0] mode_w;
    logic [`DCG_ERRW-1:0] eff_w;

    always_comb begin
        cfg = i_use_cut ? i_cut_cfg : i_rapid_cfg;
        if (cfg.mode == DCG_AD_EXP) begin
            td_ms = {1'b0, cfg.ts, 1'b0} + 14'(i_margin_ms);
        end else begin
            td_ms = {2'b00, cfg.ts} + 14'(i_margin_ms);
        end
        o_td_cyc = 32'(td_ms) * 32'(CYC_PER_MS);
        mode_w   = i_use_cut ? i_cut_width : i_rapid_width;
        eff_w    = (mode_w > i_servo_width) ? mode_w : i_servo_width;
        o_in_pos = i_pos_err < eff_w;
    end

endmodule

//--- hw/dcg_consts.svh
/*
  constants of the block-transition deceleration check gate:
  axis count, widths, timing, register map and field positions.
  assumes it is included by bare name; definitions only.
*/
`ifndef DCG_CONSTS_SVH
`define DCG_CONSTS_SVH

// ==========================================================
// sizes and timing
`define DCG_NAX          4
`define DCG_NGRP         4
`define DCG_ERRW         16
`define DCG_TSW          12
`define DCG_CLK_NS       20
`define DCG_MS_NS        1000000
`define DCG_CYC_PER_MS   (`DCG_MS_NS / `DCG_CLK_NS)
`define DCG_MARGIN_MAX   4'ha

// ==========================================================
// register map: ctrl 0x00, status 0x04, groups 0x10..0x4c
`define DCG_REG_CTRL     8'h00
`define DCG_REG_STAT     8'h04
`define DCG_ADR_GRP      7:4
`define DCG_ADR_IDX      3:2
`define DCG_GRP_BASE     4'h1
`define DCG_GRP_LAST     4'h4
`define DCG_GI_RAPID     0
`define DCG_GI_CUT       1
`define DCG_GI_SVW       2
`define DCG_GI_MODEW     3

// ==========================================================
// control fields
`define DCG_CTL_RMETH    1:0
`define DCG_CTL_TYPE     2
`define DCG_CTL_SMTH     3
`define DCG_CTL_REVR     4
`define DCG_CTL_REVC     5
`define DCG_CTL_MARGIN   11:8
`define DCG_CTL_RST      32'h0000_0000
`define DCG_CTL_MASK     32'h0000_0f3f
`define DCG_METH_BAD     2'h3

// ==========================================================
// status fields
`define DCG_ST_BUSY      0
`define DCG_ST_STATE     2:1
`define DCG_ST_METH      5:4
`define DCG_ST_SMZ       8
`define DCG_ST_INPOS     9

// ==========================================================
// per-axis fields
`define DCG_AX_TS        11:0
`define DCG_AX_MODE      17:16
`define DCG_AX_MASK      32'h0003_0fff
`define DCG_SVW_F        15:0
`define DCG_SVW_MASK     32'h0000_ffff
`define DCG_MW_RAPID     15:0
`define DCG_MW_CUT       31:16
`define DCG_MW_MASK      32'hffff_ffff

`endif

//--- hw/dcg_pkg.sv
/*
  types of the deceleration check gate.
  assumes dcg_consts.svh is on the include path.
*/
`include "dcg_consts.svh"
package dcg_pkg;

    typedef enum logic [1:0] {
        DCG_M_CMD    = 2'h0,
        DCG_M_INPOS  = 2'h1,
        DCG_M_SMOOTH = 2'h2
    } dcg_meth_t;

    typedef enum logic [1:0] {
        DCG_AD_LIN  = 2'h0,
        DCG_AD_EXP  = 2'h1,
        DCG_AD_SOFT = 2'h2
    } dcg_acc_t;

    typedef enum logic [1:0] {
        DCG_S_IDLE   = 2'b00,
        DCG_S_CMD    = 2'b01,
        DCG_S_SETTLE = 2'b11,
        DCG_S_REL    = 2'b10
    } dcg_state_t;

    typedef struct packed {
        logic                rapid;
        logic                cut;
        logic [`DCG_NAX-1:0] axes;
        logic [`DCG_NAX-1:0] dir;
    } dcg_blk_t;

    typedef struct packed {
        logic [`DCG_TSW-1:0] ts;
        logic [1:0]          mode;
    } dcg_acc_cfg_t;

    typedef logic [`DCG_NAX-1:0][`DCG_ERRW-1:0] dcg_err_t;

endpackage

//--- hw/dcg_top.sv
/*
  block-transition deceleration check gate: holds off the
  next motion block until the selected check passes.
  assumes one 50 MHz clock, inputs synchronous to it, and an
  interpolator that pulses block-done once per block end.
*/
//
// Overview of operation
// - rapid blocks with axis movement always get a block-end deceleration check
// - cutting blocks checked only on error-detect, G09, G61 or enabled reversal
// - a G00/G01 block without axis movement is never checked
// - cut then rapid with reversal and enable: command check
// - cut then cut with reversal and enable: command check
// - one reversing axis is enough to count as reversal
// - rapid method setting: 0 command, 1 in-position, 2 smoothing
// - rapid and cutting methods are set independently
// - check type 1 makes exact-stop cutting blocks use the rapid method
// - command method waits the decel time before release
// - wait is the longest check time of commanded axes
// - check time is constant, doubled if exponential, plus margin
// - rapid and cutting profiles give their own check times
// - smoothing method then waits for all-axis smoothing zero
// - in-position method then waits for errors under width
// - in-position width is larger of servo and mode width
`include "dcg_consts.svh"
module dcg_top
    import dcg_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `DCG_CYC_PER_MS
)
(
    input  wire logic                I_MCLK,
    input  wire logic                I_RST,
    input  wire logic [7:0]          I_AVS_ADDRESS,
    input  wire logic                I_AVS_READ,
    input  wire logic                I_AVS_WRITE,
    input  wire logic [31:0]         I_AVS_WRITEDATA,
    input  wire logic [3:0]          I_AVS_BYTEENABLE,
    output logic [31:0]              O_AVS_READDATA,
    output logic                     O_AVS_WAITREQUEST,
    input  wire logic                I_BLK_DONE,
    input  wire dcg_blk_t            I_CUR_BLK,
    input  wire dcg_blk_t            I_NXT_BLK,
    input  wire logic                I_EXACT_STOP_BLK,
    input  wire logic                I_EXACT_STOP_MODAL,
    input  wire logic                I_ERR_DETECT,
    input  wire logic [`DCG_NAX-1:0] I_SMOOTH_ZERO,
    input  wire dcg_err_t            I_POS_ERR,
    output logic                     O_NEXT_REL,
    output logic                     O_CHECK_BUSY
);

    localparam logic [31:0] GRP_MASK [`DCG_NGRP] = '{
        `DCG_AX_MASK, `DCG_AX_MASK, `DCG_SVW_MASK, `DCG_MW_MASK
    };

    // ==========================================================
    // register bus
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] ctl_r;
    logic [31:0] ctl_nxt;
    logic [31:0] cfg_r   [`DCG_NGRP][`DCG_NAX];
    logic [31:0] cfg_nxt [`DCG_NGRP][`DCG_NAX];
    logic [31:0] stat;
    logic        req;
    logic        grp_ok;
    logic [3:0]  grp;
    logic [1:0]  gi;
    logic [1:0]  ai;

    // ==========================================================
    // check sequencing
    dcg_state_t          st_r;
    dcg_state_t          st_nxt;
    dcg_meth_t           meth_r;
    dcg_meth_t           meth_nxt;
    logic                cut_r;
    logic                cut_nxt;
    logic [31:0]         cnt_r;
    logic [31:0]         cnt_nxt;
    logic [31:0]         td_cyc [`DCG_NAX];
    logic [31:0]         td_max;
    logic [`DCG_NAX-1:0] in_pos;
    logic                use_cut;
    logic [3:0]          margin;
    logic                moved;
    logic                rev;
    logic                exact;
    logic                rev_chk;
    logic                need;
    dcg_meth_t           rapid_meth;
    dcg_meth_t           cut_meth;
    dcg_meth_t           meth_sel;

    function automatic logic [31:0] be_merge(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // address decode
    // one wait state on every access keeps read data registered
    assign req               = I_AVS_READ | I_AVS_WRITE;
    assign grp               = I_AVS_ADDRESS[`DCG_ADR_GRP];
    assign ai                = I_AVS_ADDRESS[`DCG_ADR_IDX];
    assign grp_ok            = (grp >= `DCG_GRP_BASE) && (grp <= `DCG_GRP_LAST);
    assign gi                = 2'(grp - `DCG_GRP_BASE);
    assign O_AVS_WAITREQUEST = req & ~ack_r;
    assign O_AVS_READDATA    = rdata_r;

    always_comb begin
        stat                = '0;
        stat[`DCG_ST_BUSY]  = O_CHECK_BUSY;
        stat[`DCG_ST_STATE] = st_r;
        stat[`DCG_ST_METH]  = meth_r;
        stat[`DCG_ST_SMZ]   = &I_SMOOTH_ZERO;
        stat[`DCG_ST_INPOS] = &in_pos;
    end

    always_comb begin
        ack_nxt   = req & ~ack_r;
        rdata_nxt = rdata_r;
        ctl_nxt   = ctl_r;
        cfg_nxt   = cfg_r;
        // unmapped reads answer zero, unmapped writes are dropped
        if (I_AVS_READ && !ack_r) begin
            if (I_AVS_ADDRESS == `DCG_REG_CTRL) begin
                rdata_nxt = ctl_r;
            end else if (I_AVS_ADDRESS == `DCG_REG_STAT) begin
                rdata_nxt = stat;
            end else if (grp_ok) begin
                rdata_nxt = cfg_r[gi][ai];
            end else begin
                rdata_nxt = '0;
            end
        end
        if (I_AVS_WRITE && ack_r) begin
            if (I_AVS_ADDRESS == `DCG_REG_CTRL) begin
                ctl_nxt = be_merge(ctl_r, I_AVS_WRITEDATA, I_AVS_BYTEENABLE) & `DCG_CTL_MASK;
            end else if (grp_ok) begin
                cfg_nxt[gi][ai] = be_merge(cfg_r[gi][ai], I_AVS_WRITEDATA, I_AVS_BYTEENABLE) & GRP_MASK[gi];
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
            ctl_r   <= `DCG_CTL_RST;
            for (int g = 0; g < `DCG_NGRP; g++) begin
                for (int a = 0; a < `DCG_NAX; a++) begin
                    cfg_r[g][a] <= '0;
                end
            end
        end else begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
            ctl_r   <= ctl_nxt;
            cfg_r   <= cfg_nxt;
        end
    end

    // ==========================================================
    // per-axis check times and in-position
    // profile follows the block being checked
    assign use_cut = (st_r == DCG_S_IDLE) ? I_CUR_BLK.cut : cut_r;
    // margin beyond the documented range is clamped
    assign margin  = (ctl_r[`DCG_CTL_MARGIN] > `DCG_MARGIN_MAX) ? `DCG_MARGIN_MAX : ctl_r[`DCG_CTL_MARGIN];

    for (genvar a = 0; a < `DCG_NAX; a++) begin : g_ax
        dcg_acc_cfg_t rcfg;
        dcg_acc_cfg_t ccfg;
        assign rcfg.ts   = cfg_r[`DCG_GI_RAPID][a][`DCG_AX_TS];
        assign rcfg.mode = cfg_r[`DCG_GI_RAPID][a][`DCG_AX_MODE];
        assign ccfg.ts   = cfg_r[`DCG_GI_CUT][a][`DCG_AX_TS];
        assign ccfg.mode = cfg_r[`DCG_GI_CUT][a][`DCG_AX_MODE];
        dcg_axis_time #(
            .CYC_PER_MS (CYC_PER_MS)
        ) u_ax (
            .i_rapid_cfg   (rcfg),
            .i_cut_cfg     (ccfg),
            .i_use_cut     (use_cut),
            .i_margin_ms   (margin),
            .i_servo_width (cfg_r[`DCG_GI_SVW][a][`DCG_SVW_F]),
            .i_rapid_width (cfg_r[`DCG_GI_MODEW][a][`DCG_MW_RAPID]),
            .i_cut_width   (cfg_r[`DCG_GI_MODEW][a][`DCG_MW_CUT]),
            .i_pos_err     (I_POS_ERR[a]),
            .o_td_cyc      (td_cyc[a]),
            .o_in_pos      (in_pos[a])
        );
    end

    // longest time of the commanded axes
    always_comb begin
        td_max = '0;
        for (int a = 0; a < `DCG_NAX; a++) begin
            if (I_CUR_BLK.axes[a] && (td_cyc[a] > td_max)) begin
                td_max = td_cyc[a];
            end
        end
    end

    // ==========================================================
    // check decision at the block joint
    always_comb begin
        // undefined setting falls back to command method
        if (ctl_r[`DCG_CTL_RMETH] == `DCG_METH_BAD) begin
            rapid_meth = DCG_M_CMD;
        end else begin
            rapid_meth = dcg_meth_t'(ctl_r[`DCG_CTL_RMETH]);
        end
        // cutting method chosen on its own
        // type select hands exact-stop cutting blocks the rapid method
        if (ctl_r[`DCG_CTL_TYPE]) begin
            cut_meth = rapid_meth;
        end else begin
            cut_meth = ctl_r[`DCG_CTL_SMTH] ? DCG_M_SMOOTH : DCG_M_CMD;
        end
        moved   = |I_CUR_BLK.axes;
        // any single axis turning round counts
        rev     = |(I_CUR_BLK.axes & I_NXT_BLK.axes & (I_CUR_BLK.dir ^ I_NXT_BLK.dir));
        exact   = I_ERR_DETECT | I_EXACT_STOP_BLK | I_EXACT_STOP_MODAL;
        // reversal checks per following block kind
        rev_chk = rev & ((I_NXT_BLK.rapid & ctl_r[`DCG_CTL_REVR]) | (I_NXT_BLK.cut & ctl_r[`DCG_CTL_REVC]));
        need    = moved & (I_CUR_BLK.rapid | (I_CUR_BLK.cut & (exact | rev_chk)));
        if (I_CUR_BLK.rapid) begin
            meth_sel = rapid_meth;
        end else if (exact) begin
            meth_sel = cut_meth;
        end else begin
            meth_sel = DCG_M_CMD;
        end
    end

    // ==========================================================
    // check state machine
    always_comb begin
        st_nxt   = st_r;
        meth_nxt = meth_r;
        cut_nxt  = cut_r;
        cnt_nxt  = cnt_r;
        unique case (st_r)
            DCG_S_IDLE: begin
                if (I_BLK_DONE) begin
                    cut_nxt = I_CUR_BLK.cut;
                    if (need) begin
                        st_nxt   = DCG_S_CMD;
                        meth_nxt = meth_sel;
                        cnt_nxt  = td_max;
                    end else begin
                        st_nxt = DCG_S_REL;
                    end
                end
            end
            DCG_S_CMD: begin
                // hold until the decel time has run out
                if (cnt_r > 32'h1) begin
                    cnt_nxt = cnt_r - 32'h1;
                end else begin
                    cnt_nxt = '0;
                    st_nxt  = (meth_r == DCG_M_CMD) ? DCG_S_REL : DCG_S_SETTLE;
                end
            end
            DCG_S_SETTLE: begin
                // smoothing zero, plus in-position if chosen
                if ((&I_SMOOTH_ZERO) && ((meth_r == DCG_M_SMOOTH) || (&in_pos))) begin
                    st_nxt = DCG_S_REL;
                end
            end
            DCG_S_REL: begin
                st_nxt = DCG_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            st_r   <= DCG_S_IDLE;
            meth_r <= DCG_M_CMD;
            cut_r  <= 1'b0;
            cnt_r  <= '0;
        end else begin
            st_r   <= st_nxt;
            meth_r <= meth_nxt;
            cut_r  <= cut_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    // single strobe, busy covers the whole check
    assign O_NEXT_REL   = (st_r == DCG_S_REL);
    assign O_CHECK_BUSY = (st_r == DCG_S_CMD) || (st_r == DCG_S_SETTLE);

    // ==========================================================
    // assertions
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_RST);

    sequence s_take;
        (st_r == DCG_S_IDLE) && I_BLK_DONE;
    endsequence

    sequence s_take_moved;
        s_take ##0 moved;
    endsequence

    sequence s_release;
        O_NEXT_REL ##1 !O_NEXT_REL;
    endsequence

    chk_rapid_every:   assert property (
        s_take_moved ##0 I_CUR_BLK.rapid |=> st_r == DCG_S_CMD)
        else $error("rapid block skipped the check");

    chk_cut_plain:     assert property (
        s_take_moved ##0 (I_CUR_BLK.cut && !exact && !rev_chk) |=> s_release)
        else $error("plain cutting block was held");

    chk_cut_exact:     assert property (
        s_take_moved ##0 (I_CUR_BLK.cut && exact) |=> st_r == DCG_S_CMD)
        else $error("exact stop cutting block not checked");

    chk_no_move:       assert property (
        s_take ##0 !moved |=> s_release)
        else $error("block without movement was checked");

    chk_rev_rapid:     assert property (
        s_take_moved ##0 (I_CUR_BLK.cut && !exact && I_NXT_BLK.rapid && ctl_r[`DCG_CTL_REVR] && rev)
        |=> (st_r == DCG_S_CMD) && (meth_r == DCG_M_CMD))
        else $error("cut to rapid reversal not checked");

    chk_rev_cut:       assert property (
        s_take_moved ##0 (I_CUR_BLK.cut && !exact && I_NXT_BLK.cut && ctl_r[`DCG_CTL_REVC] && rev)
        |=> (st_r == DCG_S_CMD) && (meth_r == DCG_M_CMD))
        else $error("cut to cut reversal not checked");

    chk_rev_one_axis:  assert property (
        s_take ##0 (I_CUR_BLK.cut && I_NXT_BLK.cut && ctl_r[`DCG_CTL_REVC] && I_CUR_BLK.axes[0]
        && I_NXT_BLK.axes[0] && (I_CUR_BLK.dir[0] != I_NXT_BLK.dir[0])) |=> st_r == DCG_S_CMD)
        else $error("single axis reversal missed");

    chk_rapid_meth:    assert property (
        s_take_moved ##0 I_CUR_BLK.rapid |=> meth_r == $past(rapid_meth))
        else $error("rapid method not taken from setting");

    chk_type_sel:      assert property (
        s_take_moved ##0 (I_CUR_BLK.cut && exact && ctl_r[`DCG_CTL_TYPE])
        |=> meth_r == $past(rapid_meth))
        else $error("type select did not apply rapid method");

    chk_wait_load:     assert property (
        s_take_moved ##0 need |=> cnt_r == $past(td_max))
        else $error("wait not loaded with longest axis time");

    chk_cmd_hold:      assert property (
        (st_r == DCG_S_CMD) && (cnt_r > 32'h1)
        |=> (st_r == DCG_S_CMD) && (cnt_r == $past(cnt_r) - 32'h1) && !O_NEXT_REL)
        else $error("command wait ended early");

    chk_smooth_hold:   assert property (
        (st_r == DCG_S_SETTLE) && !(&I_SMOOTH_ZERO) |=> st_r == DCG_S_SETTLE)
        else $error("advanced before smoothing zero");

    chk_inpos_hold:    assert property (
        (st_r == DCG_S_SETTLE) && (meth_r == DCG_M_INPOS) && !(&in_pos) |=> st_r == DCG_S_SETTLE)
        else $error("advanced before in-position");

    chk_rel_single:    assert property (
        O_NEXT_REL |-> !O_CHECK_BUSY ##1 (!O_NEXT_REL && (st_r == DCG_S_IDLE)))
        else $error("release strobe not a single cycle");

endmodule

//--- sim/dcg_far_model.sv
/*
  far-side model: interpolator end, axis smoothing and servo error.
  assumes the bench pulses i_blk_done only while the gate is idle.
*/
module dcg_far_model
    import dcg_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_blk_done,
    input  wire logic [15:0] i_dly,
    input  wire logic [15:0] i_err_final,
    output logic [3:0]       o_smooth_zero,
    output dcg_err_t         o_pos_err
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] cnt_r;
    // ==========================================================
    // settling countdown
    // axes stay unsettled, with error at the complement of i_err_final, until it runs out
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= 16'h0000;
        end else if (i_blk_done) begin
            cnt_r <= i_dly;
        end else if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
        end
    end
    assign o_smooth_zero = (cnt_r == 16'h0000) ? 4'hf : 4'h0;
    assign o_pos_err     = (cnt_r == 16'h0000) ? {4{i_err_final}} : {4{~i_err_final}};
endmodule

//--- sim/tb_dcg_top.sv
/*
  testbench of the deceleration check gate: register access and
  block joints, checked against release latency.
  assumes dcg_far_model drives smoothing and position error.
*/
`include "dcg_consts.svh"
module tb_dcg_top
    import dcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CYC = 5;
    localparam int M   = 3;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  be = 4'hf;
    logic        done = 1'b0;
    dcg_blk_t    cur = '0;
    dcg_blk_t    nxt = '0;
    logic        es_blk = 1'b0;
    logic        es_mod = 1'b0;
    logic        err_det = 1'b0;
    logic [15:0] dly = 16'd100;
    logic [15:0] errf = 16'hffff;
    logic [31:0] rdat;
    logic        wreq;
    logic [3:0]  smz;
    dcg_err_t    perr;
    logic        rel;
    logic        busy;
    int          errors = 0;
    int          n_checks = 0;
    int          k;

    always #10 mclk = ~mclk;

    dcg_top #(.CYC_PER_MS(CYC)) u_dut (.I_MCLK(mclk), .I_RST(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat),
        .O_AVS_WAITREQUEST(wreq), .I_BLK_DONE(done), .I_CUR_BLK(cur), .I_NXT_BLK(nxt),
        .I_EXACT_STOP_BLK(es_blk), .I_EXACT_STOP_MODAL(es_mod), .I_ERR_DETECT(err_det),
        .I_SMOOTH_ZERO(smz), .I_POS_ERR(perr), .O_NEXT_REL(rel), .O_CHECK_BUSY(busy));
    dcg_far_model u_far (.i_clk(mclk), .i_rst(rst), .i_blk_done(done), .i_dly(dly),
        .i_err_final(errf), .o_smooth_zero(smz), .o_pos_err(perr));

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic av_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge mclk);
        adr <= a;
        wdat <= d;
        be <= b;
        wr <= 1'b1;
        @(posedge mclk);
        while (wreq !== 1'b0) @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic av_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        adr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        while (wreq !== 1'b0) @(posedge mclk);
        chk(rdat, exp);
        rd <= 1'b0;
    endtask

    // one block joint; k counts cycles from the sampling edge to release
    task automatic blk(input logic r, input logic [3:0] ax, input logic nr, input logic [3:0] nd);
        logic seen;
        @(posedge mclk);
        done <= 1'b1;
        cur <= '{rapid: r, cut: ~r, axes: ax, dir: 4'h0};
        nxt <= '{rapid: nr, cut: ~nr, axes: ax, dir: nd};
        @(posedge mclk);
        done <= 1'b0;
        k = 1;
        seen = 1'b0;
        // outputs are sampled at the edge, as the block sequencer would
        @(posedge mclk);
        while (rel !== 1'b1 && k < 3000) begin
            seen = seen | busy;
            @(posedge mclk);
            k++;
        end
        // busy seen during the wait, off at release
        chk(busy, 1'b0);
        chk(seen, 1'(k > 1));
    endtask

    function automatic int kx(input int ms);
        return ms * CYC + 1;
    endfunction

    // ==========================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        stop_test();
    end

    // ==========================================================
    // tests
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        av_rd(`DCG_REG_CTRL, 32'h0);
        av_rd(`DCG_REG_STAT, 32'h0000_0100);
        av_rd(8'h80, 32'h0);
        av_wr(`DCG_REG_CTRL, 32'h0000_003f, 4'hf);
        av_wr(`DCG_REG_CTRL, 32'hffff_0300, 4'h2);
        av_rd(`DCG_REG_CTRL, 32'h0000_033f);
        av_wr(`DCG_REG_CTRL, 32'h0000_0300, 4'hf);
        av_wr(8'h10, 32'h0000_0002, 4'hf);
        av_wr(8'h14, 32'h0001_0003, 4'hf);
        av_wr(8'h18, 32'h0002_0007, 4'hf);
        av_rd(8'h14, 32'h0001_0003);
        av_wr(8'h20, 32'h0000_0001, 4'hf);
        av_wr(8'h24, 32'h0000_0002, 4'hf);
        for (int i = 0; i < 4; i++) begin
            av_wr(8'(8'h30 + 4 * i), 32'h0000_0010, 4'hf);
            av_wr(8'(8'h40 + 4 * i), 32'h0010_0020, 4'hf);
        end
        // axis 2 has the longest rapid time but is not commanded
        blk(1'b1, 4'h3, 1'b0, 4'h0);
        chk(k, kx(2 * 3 + M));
        blk(1'b1, 4'h0, 1'b1, 4'h0);
        chk(k, 1);
        blk(1'b0, 4'h3, 1'b0, 4'h0);
        chk(k, 1);
        for (int c = 0; c < 3; c++) begin
            err_det <= (c == 0);
            es_blk <= (c == 1);
            es_mod <= (c == 2);
            blk(1'b0, 4'h3, 1'b0, 4'h0);
            chk(k, kx(2 + M));
        end
        es_mod <= 1'b0;
        blk(1'b0, 4'h3, 1'b1, 4'h2);
        chk(k, 1);
        av_wr(`DCG_REG_CTRL, 32'h0000_0310, 4'hf);
        blk(1'b0, 4'h3, 1'b1, 4'h2);
        chk(k, kx(2 + M));
        av_wr(`DCG_REG_CTRL, 32'h0000_0320, 4'hf);
        blk(1'b0, 4'h3, 1'b0, 4'h1);
        chk(k, kx(2 + M));
        av_wr(`DCG_REG_CTRL, 32'h0000_0302, 4'hf);
        blk(1'b1, 4'h3, 1'b1, 4'h0);
        chk(32'(k > dly && k <= dly + 4), 1);
        errf <= 16'h0018;
        av_wr(`DCG_REG_CTRL, 32'h0000_0301, 4'hf);
        blk(1'b1, 4'h3, 1'b1, 4'h0);
        chk(32'(k > dly && k <= dly + 4), 1);
        es_blk <= 1'b1;
        av_wr(`DCG_REG_CTRL, 32'h0000_030c, 4'hf);
        blk(1'b0, 4'h3, 1'b0, 4'h0);
        chk(k, kx(2 + M));
        av_wr(`DCG_REG_CTRL, 32'h0000_0308, 4'hf);
        blk(1'b0, 4'h3, 1'b0, 4'h0);
        chk(32'(k > dly && k <= dly + 4), 1);
        blk(1'b1, 4'h3, 1'b0, 4'h0);
        chk(k, kx(2 * 3 + M));
        stop_test();
    end
endmodule
